// ===== common/intc_pkg.sv
// constants, field positions and carrier types for the interrupt
// enable and priority block; assumes an 8-bit special-register port.
package intc_pkg;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_EXT_PIN_EN = 8'h84;
  localparam logic [7:0] ADDR_P1_WAKE = 8'h96;
  localparam logic [7:0] ADDR_PWM_OUT_EN = 8'h9E;
  localparam logic [7:0] ADDR_PWM_CLR_EN = 8'h9F;
  localparam logic [7:0] ADDR_INT_EN_1 = 8'hA8;
  localparam logic [7:0] ADDR_INT_EN_2 = 8'hA9;
  localparam logic [7:0] ADDR_PRIO_LO_1 = 8'hB8;
  localparam logic [7:0] ADDR_PRIO_HI_1 = 8'hB9;
  localparam logic [7:0] ADDR_PRIO_LO_2 = 8'hBA;
  localparam logic [7:0] ADDR_PRIO_HI_2 = 8'hBB;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // implemented bits; the rest read as zero
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_INT_EN_1 = 8'hBF;
  localparam logic [7:0] MASK_PRIO_1 = 8'h3F;
  localparam logic [7:0] MASK_PWM_OUT = 8'hC0;
  localparam logic [7:0] MASK_PWM_CLR = 8'h80;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_TIMER2 = 5;
  localparam int BIT_UART1 = 4;
  localparam int BIT_TIMER1 = 3;
  localparam int BIT_PIN1 = 2;
  localparam int BIT_TIMER0 = 1;
  localparam int BIT_PIN0 = 0;
  localparam int BIT_PWM = 7;
  localparam int BIT_TWO_WIRE = 6;
  localparam int BIT_UART2 = 5;
  localparam int BIT_SER_PERIPH = 4;
  localparam int BIT_ADC_TOUCH = 3;
  localparam int BIT_PIN_LVD = 2;
  localparam int BIT_PORT1 = 1;
  localparam int BIT_TIMER3 = 0;
  localparam int BIT_PWM1_IE = 7;
  localparam int BIT_PWM0_IE = 6;
  localparam int BIT_PWM2_IE = 7;

  // ****************************************************************
  // source slots in vector order
  // ****************************************************************
  localparam int NUM_SLOTS = 15;
  localparam int SLOT_W = 4;
  localparam int NUM_LEVELS = 4;
  localparam logic [3:0] SLOT_PIN0 = 4'h0;
  localparam logic [3:0] SLOT_TIMER0 = 4'h1;
  localparam logic [3:0] SLOT_PIN1 = 4'h2;
  localparam logic [3:0] SLOT_TIMER1 = 4'h3;
  localparam logic [3:0] SLOT_UART1 = 4'h4;
  localparam logic [3:0] SLOT_TIMER2 = 4'h5;
  localparam logic [3:0] SLOT_RESERVED = 4'h6;
  localparam logic [3:0] SLOT_TIMER3 = 4'h7;
  localparam logic [3:0] SLOT_PORT1 = 4'h8;
  localparam logic [3:0] SLOT_PIN_LVD = 4'h9;
  localparam logic [3:0] SLOT_ADC_TOUCH = 4'hA;
  localparam logic [3:0] SLOT_SER_PERIPH = 4'hB;
  localparam logic [3:0] SLOT_UART2 = 4'hC;
  localparam logic [3:0] SLOT_TWO_WIRE = 4'hD;
  localparam logic [3:0] SLOT_PWM = 4'hE;

  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef logic [1:0] prio_t;
  typedef logic [NUM_SLOTS-1:0][1:0] prio_vec_t;

  typedef struct packed {
    logic pin0;
    logic pin1;
    logic [7:0] pin2to9;
    logic low_voltage_detector;
    logic [7:0] port1_change;
    logic timer0;
    logic timer1;
    logic timer2;
    logic timer3;
    logic uart1;
    logic uart2;
    logic serial_periph;
    logic two_wire;
    logic adc_touch;
    logic [2:0] pwm;
  } src_flags_t;

  typedef struct packed {
    logic valid;
    prio_t level;
    logic [SLOT_W-1:0] slot;
  } req_t;

  function automatic prio_t prio_of(input logic hi, input logic lo);
    return {hi, lo};
  endfunction

  function automatic logic [15:0] vector_of(input logic [3:0] slot);
    return VEC_BASE + ({12'h000, slot} << VEC_SHIFT);
  endfunction

endpackage

// ===== core/intc_top.sv
// interrupt enable, stop wake enable and four-level priority block;
// assumes flags are held by their sources until software clears them,
// and a cpu that acks a request and signals handler return.
//
// Contract
// - eight enable bits let pins INT2..INT9 interrupt and wake stop mode.
// - INT2..INT9 act only with own bit and shared group bit set.
// - enabled pins wake stop mode whatever the global gate says.
// - eight-bit port1 mask enables each pin's change for wake and interrupt.
// - each PWM channel interrupts only with its bit and group bit.
// - global gate 0 blocks all; at 1 each source uses its own bit.
// - first enable register: timer2 b5, uart1 b4, timer1 b3, timer0 b1.
// - INT1 b2 and INT0 b0 gate pin interrupt and stop wake.
// - second register: PWM b7, I2C b6, UART2 b5, SPI b4, ADC b3, timer3 b0.
// - one shared bit gates INT2..INT9, their wake, and low-voltage interrupt.
// - port1 change enable gates the interrupt only, never the wake.
// - priority from high and low bit, 11 highest, 00 lowest.
// - first priority pair: timer2 5, uart1 4, timer1 3, INT1 2, timer0 1, INT0 0.
// - second pair: PWM 7, I2C 6, UART2 5, SPI 4, ADC 3, pins 2, P1 1, T3 0.
// - only a strictly higher level preempts a running handler.
// - flags set on events whatever the enable bits hold.
// - vectors eight bytes apart from 0003 to 0073; pins and LOW_VOLTAGE_DETECTOR share 004B.
// - only pins wake stop mode; any enabled interrupt wakes idle.
`timescale 1ns/1ps
module intc_top
  import intc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire src_flags_t i_flags,
  input wire logic i_int_ack,
  input wire logic i_reti,
  output logic [7:0] o_sfr_rdata,
  output logic o_int_req,
  output logic [15:0] o_vector,
  output logic [1:0] o_req_level,
  output logic [NUM_LEVELS-1:0] o_in_service,
  output logic o_stop_wake,
  output logic o_idle_wake
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0] ext_pin_int_enable_reg;
  logic [7:0] port1_wake_mask_reg;
  logic [7:0] pwm_output_int_enable_reg;
  logic [7:0] pwm_clear_int_enable_reg;
  logic [7:0] int_enable_first_reg;
  logic [7:0] int_enable_second_reg;
  logic [7:0] prio_low_first_reg;
  logic [7:0] prio_high_first_reg;
  logic [7:0] prio_low_second_reg;
  logic [7:0] prio_high_second_reg;
  logic [NUM_LEVELS-1:0] in_service_reg;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] target);
    return addr == target;
  endfunction

  wire logic wr_ext = i_sfr_wr & hit(i_sfr_addr, ADDR_EXT_PIN_EN);
  wire logic wr_p1 = i_sfr_wr & hit(i_sfr_addr, ADDR_P1_WAKE);
  wire logic wr_pwm_out = i_sfr_wr & hit(i_sfr_addr, ADDR_PWM_OUT_EN);
  wire logic wr_pwm_clr = i_sfr_wr & hit(i_sfr_addr, ADDR_PWM_CLR_EN);
  wire logic wr_en_1 = i_sfr_wr & hit(i_sfr_addr, ADDR_INT_EN_1);
  wire logic wr_en_2 = i_sfr_wr & hit(i_sfr_addr, ADDR_INT_EN_2);
  wire logic wr_lo_1 = i_sfr_wr & hit(i_sfr_addr, ADDR_PRIO_LO_1);
  wire logic wr_hi_1 = i_sfr_wr & hit(i_sfr_addr, ADDR_PRIO_HI_1);
  wire logic wr_lo_2 = i_sfr_wr & hit(i_sfr_addr, ADDR_PRIO_LO_2);
  wire logic wr_hi_2 = i_sfr_wr & hit(i_sfr_addr, ADDR_PRIO_HI_2);

  // ****************************************************************
  // next register values
  // ****************************************************************
  // unimplemented bits are dropped on write so reads show zero there
  wire logic [7:0] ext_pin_int_enable_next = wr_ext ?
    (i_sfr_wdata & MASK_FULL) : ext_pin_int_enable_reg;
  wire logic [7:0] port1_wake_mask_next = wr_p1 ?
    (i_sfr_wdata & MASK_FULL) : port1_wake_mask_reg;
  wire logic [7:0] pwm_output_int_enable_next = wr_pwm_out ?
    (i_sfr_wdata & MASK_PWM_OUT) : pwm_output_int_enable_reg;
  wire logic [7:0] pwm_clear_int_enable_next = wr_pwm_clr ?
    (i_sfr_wdata & MASK_PWM_CLR) : pwm_clear_int_enable_reg;
  wire logic [7:0] int_enable_first_next = wr_en_1 ?
    (i_sfr_wdata & MASK_INT_EN_1) : int_enable_first_reg;
  wire logic [7:0] int_enable_second_next = wr_en_2 ?
    (i_sfr_wdata & MASK_FULL) : int_enable_second_reg;
  wire logic [7:0] prio_low_first_next = wr_lo_1 ?
    (i_sfr_wdata & MASK_PRIO_1) : prio_low_first_reg;
  wire logic [7:0] prio_high_first_next = wr_hi_1 ?
    (i_sfr_wdata & MASK_PRIO_1) : prio_high_first_reg;
  wire logic [7:0] prio_low_second_next = wr_lo_2 ?
    (i_sfr_wdata & MASK_FULL) : prio_low_second_reg;
  wire logic [7:0] prio_high_second_next = wr_hi_2 ?
    (i_sfr_wdata & MASK_FULL) : prio_high_second_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_pin_int_enable_reg <= REG_RESET;
      port1_wake_mask_reg <= REG_RESET;
      pwm_output_int_enable_reg <= REG_RESET;
      pwm_clear_int_enable_reg <= REG_RESET;
      int_enable_first_reg <= REG_RESET;
      int_enable_second_reg <= REG_RESET;
    end else if (i_clk_en) begin
      ext_pin_int_enable_reg <= ext_pin_int_enable_next;
      port1_wake_mask_reg <= port1_wake_mask_next;
      pwm_output_int_enable_reg <= pwm_output_int_enable_next;
      pwm_clear_int_enable_reg <= pwm_clear_int_enable_next;
      int_enable_first_reg <= int_enable_first_next;
      int_enable_second_reg <= int_enable_second_next;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prio_low_first_reg <= REG_RESET;
      prio_high_first_reg <= REG_RESET;
      prio_low_second_reg <= REG_RESET;
      prio_high_second_reg <= REG_RESET;
    end else if (i_clk_en) begin
      prio_low_first_reg <= prio_low_first_next;
      prio_high_first_reg <= prio_high_first_next;
      prio_low_second_reg <= prio_low_second_next;
      prio_high_second_reg <= prio_high_second_next;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // unmapped addresses read as zero rather than holding the bus value
  wire logic [7:0] rdata_next =
    hit(i_sfr_addr, ADDR_EXT_PIN_EN) ? ext_pin_int_enable_reg :
    hit(i_sfr_addr, ADDR_P1_WAKE) ? port1_wake_mask_reg :
    hit(i_sfr_addr, ADDR_PWM_OUT_EN) ? pwm_output_int_enable_reg :
    hit(i_sfr_addr, ADDR_PWM_CLR_EN) ? pwm_clear_int_enable_reg :
    hit(i_sfr_addr, ADDR_INT_EN_1) ? int_enable_first_reg :
    hit(i_sfr_addr, ADDR_INT_EN_2) ? int_enable_second_reg :
    hit(i_sfr_addr, ADDR_PRIO_LO_1) ? prio_low_first_reg :
    hit(i_sfr_addr, ADDR_PRIO_HI_1) ? prio_high_first_reg :
    hit(i_sfr_addr, ADDR_PRIO_LO_2) ? prio_low_second_reg :
    hit(i_sfr_addr, ADDR_PRIO_HI_2) ? prio_high_second_reg :
    RDATA_NONE;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= RDATA_NONE;
    end else if (i_clk_en && i_sfr_rd) begin
      o_sfr_rdata <= rdata_next;
    end
  end

  // ****************************************************************
  // priority levels per slot
  // ****************************************************************
  prio_vec_t level_vec;

  // high bit pairs with low bit of the same position.
  assign level_vec[SLOT_PIN0] = prio_of(prio_high_first_reg[BIT_PIN0],
                                        prio_low_first_reg[BIT_PIN0]);
  assign level_vec[SLOT_TIMER0] =
    prio_of(prio_high_first_reg[BIT_TIMER0], prio_low_first_reg[BIT_TIMER0]);
  assign level_vec[SLOT_PIN1] = prio_of(prio_high_first_reg[BIT_PIN1],
                                        prio_low_first_reg[BIT_PIN1]);
  assign level_vec[SLOT_TIMER1] =
    prio_of(prio_high_first_reg[BIT_TIMER1], prio_low_first_reg[BIT_TIMER1]);
  assign level_vec[SLOT_UART1] = prio_of(prio_high_first_reg[BIT_UART1],
                                         prio_low_first_reg[BIT_UART1]);
  assign level_vec[SLOT_TIMER2] =
    prio_of(prio_high_first_reg[BIT_TIMER2], prio_low_first_reg[BIT_TIMER2]);
  assign level_vec[SLOT_RESERVED] = '0;
  // second pair follows the same encoding.
  assign level_vec[SLOT_TIMER3] =
    prio_of(prio_high_second_reg[BIT_TIMER3],
            prio_low_second_reg[BIT_TIMER3]);
  assign level_vec[SLOT_PORT1] =
    prio_of(prio_high_second_reg[BIT_PORT1], prio_low_second_reg[BIT_PORT1]);
  assign level_vec[SLOT_PIN_LVD] =
    prio_of(prio_high_second_reg[BIT_PIN_LVD],
            prio_low_second_reg[BIT_PIN_LVD]);
  assign level_vec[SLOT_ADC_TOUCH] =
    prio_of(prio_high_second_reg[BIT_ADC_TOUCH],
            prio_low_second_reg[BIT_ADC_TOUCH]);
  assign level_vec[SLOT_SER_PERIPH] =
    prio_of(prio_high_second_reg[BIT_SER_PERIPH],
            prio_low_second_reg[BIT_SER_PERIPH]);
  assign level_vec[SLOT_UART2] =
    prio_of(prio_high_second_reg[BIT_UART2], prio_low_second_reg[BIT_UART2]);
  assign level_vec[SLOT_TWO_WIRE] =
    prio_of(prio_high_second_reg[BIT_TWO_WIRE],
            prio_low_second_reg[BIT_TWO_WIRE]);
  assign level_vec[SLOT_PWM] =
    prio_of(prio_high_second_reg[BIT_PWM], prio_low_second_reg[BIT_PWM]);

  // ****************************************************************
  // gating and arbitration
  // ****************************************************************
  logic [NUM_SLOTS-1:0] gated_req;
  logic stop_wake_comb;
  req_t winner;

  source_gate u_gate (
    .i_flags(i_flags),
    .i_ext_pin_en(ext_pin_int_enable_reg),
    .i_p1_wake(port1_wake_mask_reg),
    .i_pwm_out_en(pwm_output_int_enable_reg),
    .i_pwm_clr_en(pwm_clear_int_enable_reg),
    .i_int_en_1(int_enable_first_reg),
    .i_int_en_2(int_enable_second_reg),
    .o_req(gated_req),
    .o_stop_wake(stop_wake_comb)
  );

  prio_pick #(
    .SLOTS(NUM_SLOTS)
  ) u_pick (
    .i_req(gated_req),
    .i_level(level_vec),
    .o_win(winner)
  );

  // ****************************************************************
  // in-service tracking
  // ****************************************************************
  function automatic prio_t top_level(input logic [NUM_LEVELS-1:0] mask);
    prio_t lvl;
    lvl = '0;
    for (int i = 0; i < NUM_LEVELS; i++) begin
      if (mask[i]) begin
        lvl = prio_t'(i);
      end
    end
    return lvl;
  endfunction

  wire logic any_active = |in_service_reg;
  wire prio_t active_level = top_level(in_service_reg);
  // a lower handler stays marked while a higher one runs over it
  wire logic take_ack = i_int_ack & o_int_req;
  wire logic [NUM_LEVELS-1:0] ack_bit =
    take_ack ? (NUM_LEVELS'(1) << o_req_level) : '0;
  wire logic [NUM_LEVELS-1:0] ret_bit =
    (i_reti && any_active) ? (NUM_LEVELS'(1) << active_level) : '0;
  wire logic [NUM_LEVELS-1:0] in_service_next =
    (in_service_reg & ~ret_bit) | ack_bit;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_service_reg <= '0;
    end else if (i_clk_en) begin
      in_service_reg <= in_service_next;
    end
  end

  // ****************************************************************
  // request to the cpu
  // ****************************************************************
  // equal level never preempts; it waits for the handler return.
  wire logic may_preempt = winner.valid &
    (!any_active || (winner.level > active_level));
  // the cycle after an ack the stale request is dropped
  wire logic int_req_next = may_preempt & ~take_ack;
  wire logic [15:0] vector_next = vector_of(winner.slot);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_int_req <= 1'b0;
      o_vector <= VEC_BASE;
      o_req_level <= '0;
    end else if (i_clk_en) begin
      o_int_req <= int_req_next;
      o_vector <= vector_next;
      o_req_level <= winner.level;
    end
  end

  // ****************************************************************
  // wake and status outputs
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_stop_wake <= 1'b0;
      o_idle_wake <= 1'b0;
      o_in_service <= '0;
    end else if (i_clk_en) begin
      o_stop_wake <= stop_wake_comb;
      o_idle_wake <= |gated_req;
      o_in_service <= in_service_next;
    end
  end

endmodule

// ===== core/prio_pick.sv
// picks the highest-level pending slot, lowest slot first on a tie;
// assumes requests are already gated.
`timescale 1ns/1ps
module prio_pick
  import intc_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
)
(
  input wire logic [SLOTS-1:0] i_req,
  input wire prio_vec_t i_level,
  output req_t o_win
);

  // ****************************************************************
  // ripple chain
  // ****************************************************************
  req_t chain [SLOTS+1];

  assign chain[0] = '0;
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      // strict compare keeps the earlier slot on equal level.
      wire logic take = i_req[g] &
        (!chain[g].valid || (i_level[g] > chain[g].level));
      assign chain[g+1] = take ?
        req_t'{1'b1, i_level[g], SLOT_W'(g)} : chain[g];
    end
  endgenerate
  assign o_win = chain[SLOTS];
endmodule

// ===== core/source_gate.sv
// enable gating of every source into one request per vector slot,
// and the stop-mode wake term; flags arrive already latched.
`timescale 1ns/1ps
module source_gate
  import intc_pkg::*;
(
  input wire src_flags_t i_flags,
  input wire logic [7:0] i_ext_pin_en,
  input wire logic [7:0] i_p1_wake,
  input wire logic [7:0] i_pwm_out_en,
  input wire logic [7:0] i_pwm_clr_en,
  input wire logic [7:0] i_int_en_1,
  input wire logic [7:0] i_int_en_2,
  output logic [NUM_SLOTS-1:0] o_req,
  output logic o_stop_wake
);

  // ****************************************************************
  // grouped sources
  // ****************************************************************
  wire logic group_en = i_int_en_2[BIT_PIN_LVD];
  wire logic pins_hit = |(i_flags.pin2to9 & i_ext_pin_en);
  wire logic pin_lvd_hit = group_en & (pins_hit | i_flags.low_voltage_detector);
  wire logic p1_hit = |(i_flags.port1_change & i_p1_wake);
  wire logic [2:0] pwm_ch_en = {i_pwm_clr_en[BIT_PWM2_IE],
                                i_pwm_out_en[BIT_PWM1_IE],
                                i_pwm_out_en[BIT_PWM0_IE]};
  wire logic pwm_hit = i_int_en_2[BIT_PWM] & |(i_flags.pwm & pwm_ch_en);
  wire logic gate = i_int_en_1[BIT_GLOBAL];
  logic [NUM_SLOTS-1:0] local_req;

  // ****************************************************************
  // per-slot requests
  // ****************************************************************
  // flags are never masked upstream; only the request is gated.
  assign local_req[SLOT_PIN0] = i_flags.pin0 & i_int_en_1[BIT_PIN0];
  assign local_req[SLOT_TIMER0] = i_flags.timer0 & i_int_en_1[BIT_TIMER0];
  assign local_req[SLOT_PIN1] = i_flags.pin1 & i_int_en_1[BIT_PIN1];
  assign local_req[SLOT_TIMER1] = i_flags.timer1 & i_int_en_1[BIT_TIMER1];
  assign local_req[SLOT_UART1] = i_flags.uart1 & i_int_en_1[BIT_UART1];
  assign local_req[SLOT_TIMER2] = i_flags.timer2 & i_int_en_1[BIT_TIMER2];
  assign local_req[SLOT_RESERVED] = 1'b0;
  assign local_req[SLOT_TIMER3] = i_flags.timer3 & i_int_en_2[BIT_TIMER3];
  // port1 interrupt needs the pin mask and its own bit.
  assign local_req[SLOT_PORT1] = p1_hit & i_int_en_2[BIT_PORT1];
  assign local_req[SLOT_PIN_LVD] = pin_lvd_hit;
  assign local_req[SLOT_ADC_TOUCH] =
    i_flags.adc_touch & i_int_en_2[BIT_ADC_TOUCH];
  assign local_req[SLOT_SER_PERIPH] =
    i_flags.serial_periph & i_int_en_2[BIT_SER_PERIPH];
  assign local_req[SLOT_UART2] = i_flags.uart2 & i_int_en_2[BIT_UART2];
  assign local_req[SLOT_TWO_WIRE] =
    i_flags.two_wire & i_int_en_2[BIT_TWO_WIRE];
  assign local_req[SLOT_PWM] = pwm_hit;
  assign o_req = gate ? local_req : '0;

  // ****************************************************************
  // stop wake: pins only, global gate ignored
  // ****************************************************************
  // lvd is no pin, so it stays out of the wake term.
  assign o_stop_wake = (i_flags.pin0 & i_int_en_1[BIT_PIN0]) |
                       (i_flags.pin1 & i_int_en_1[BIT_PIN1]) |
                       (group_en & pins_hit) |
                       p1_hit;
endmodule

// ===== test/cpu_ack_model.sv
// cpu side: takes a pending request, promptly or after a short stall
// assumes the bench drives handler return itself
// handlers modelled here touch no pwm byte pair.
`timescale 1ns/1ps
module cpu_ack_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_take,
  input wire logic i_slow,
  input wire logic i_int_req,
  output logic o_int_ack
);
  // ****************************************************************
  // ack pulse
  // ****************************************************************
  logic [1:0] wait_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_int_ack <= 1'b0;
      wait_reg <= 2'h0;
    end else begin
      // one-cycle pulse; a slow cpu lets the request stand four cycles before the ack
      o_int_ack <= i_int_req && i_take && !o_int_ack
        && (!i_slow || wait_reg == 2'h3);
      wait_reg <= i_int_req ? wait_reg + 2'h1 : 2'h0;
    end
  end
endmodule

// ===== test/intc_top_asserts.sv
// port-level checker for the interrupt enable and priority block
// assumes one clock domain and a bind onto every intc_top instance
`timescale 1ns/1ps
module intc_top_asserts
  import intc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_sfr_rd,
  input wire src_flags_t i_flags,
  input wire logic i_int_ack,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_int_req,
  input wire logic [15:0] o_vector,
  input wire logic [1:0] o_req_level,
  input wire logic [NUM_LEVELS-1:0] o_in_service,
  input wire logic o_stop_wake,
  input wire logic o_idle_wake
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic take;
  logic pins;
  assign take = i_clk_en && i_int_ack && o_int_req;
  assign pins = i_flags.pin0 | i_flags.pin1 | (|i_flags.pin2to9)
    | (|i_flags.port1_change);
  a_ack_drops_req: assert property (take |=> !o_int_req)
    else $error("request stayed up after ack");
  a_ack_marks_level: assert property (
    take |=> o_in_service[$past(o_req_level)])
    else $error("acked level not marked in service");
  a_only_higher: assert property (
    o_int_req |-> (o_in_service >> o_req_level) == 4'h0)
    else $error("request not above the running level");
  a_vector_grid: assert property (o_int_req |-> o_vector[2:0] == 3'h3
    && o_vector <= 16'h0073 && o_vector != 16'h0033)
    else $error("vector off the grid");
  a_req_wakes_idle: assert property (o_int_req |-> o_idle_wake)
    else $error("request without idle wake");
  a_quiet_no_wake: assert property (
    i_clk_en && i_flags == '0 |=> !o_stop_wake && !o_idle_wake)
    else $error("wake without any flag");
  a_read_holds: assert property (
    !(i_clk_en && i_sfr_rd) |=> $stable(o_sfr_rdata))
    else $error("read data moved without a read");
  a_wake_pins_only: assert property (
    o_stop_wake && $past(i_clk_en) |-> $past(pins))
    else $error("stop wake from a non-pin source");
  c_ack: cover property (take);
  c_stop_only: cover property (o_stop_wake && !o_int_req);
  c_top_level: cover property (o_in_service == 4'h8);
endmodule
bind intc_top intc_top_asserts u_chk (.i_ref_clk, .i_rst_n, .i_clk_en,
  .i_sfr_rd, .i_flags, .i_int_ack, .o_sfr_rdata, .o_int_req, .o_vector,
  .o_req_level, .o_in_service, .o_stop_wake, .o_idle_wake);

// ===== test/intc_top_test.sv
// self-checking bench for intc_top with the cpu ack model
// assumes flags are held steady by the bench while checked
`timescale 1ns/1ps
module intc_top_test;
  import intc_pkg::*;
  // ****************************************************************
  // stimulus and checking
  // ****************************************************************
  typedef struct {
    logic [7:0] ie1, ie2, pin, p1m;
    logic [30:0] fl;
    logic req, wake;
    logic [15:0] vec;
  } row_t;
  row_t rows [10] = '{
    '{8'h82, 8'h00, 8'h00, 8'h00, 31'h0000800, 1'b1, 1'b0, 16'h000B},
    '{8'h02, 8'h00, 8'h00, 8'h00, 31'h0000800, 1'b0, 1'b0, 16'h000B},
    '{8'h01, 8'h00, 8'h00, 8'h00, 31'h40000000, 1'b0, 1'b1, 16'h0003},
    '{8'h80, 8'h04, 8'h08, 8'h00, 31'h1000000, 1'b1, 1'b1, 16'h004B},
    '{8'h80, 8'h00, 8'h08, 8'h00, 31'h1000000, 1'b0, 1'b0, 16'h004B},
    '{8'h80, 8'h00, 8'h00, 8'h01, 31'h0001000, 1'b0, 1'b1, 16'h0043},
    '{8'h80, 8'h02, 8'h00, 8'h01, 31'h0001000, 1'b1, 1'b1, 16'h0043},
    '{8'h80, 8'h04, 8'h00, 8'h00, 31'h0100000, 1'b1, 1'b0, 16'h004B},
    '{8'h80, 8'h40, 8'h00, 8'h00, 31'h0000010, 1'b1, 1'b0, 16'h006B},
    '{8'h80, 8'h08, 8'h00, 8'h00, 31'h0000008, 1'b1, 1'b0, 16'h0053}};
  logic clk;
  logic rst_n = 0, wr = 0, rd = 0, take = 0, slow = 1, reti = 0, cen = 1, ack;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  src_flags_t flags = '0;
  logic req, swake, iwake;
  logic [15:0] vec;
  logic [1:0] lvl;
  logic [3:0] insvc;
  int failures = 0, tests_run = 0;
  intc_top u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(cen),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
    .i_flags(flags), .i_int_ack(ack), .i_reti(reti), .o_sfr_rdata(rdata),
    .o_int_req(req), .o_vector(vec), .o_req_level(lvl),
    .o_in_service(insvc), .o_stop_wake(swake), .o_idle_wake(iwake));
  cpu_ack_model u_cpu (.i_clk(clk), .i_rst_n(rst_n), .i_take(take),
    .i_slow(slow), .i_int_req(req), .o_int_ack(ack));
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    wr = 1; addr = a; wdata = d;
    @(posedge clk) #2;
    wr = 0;
    @(posedge clk) #2;
  endtask
  task automatic rreg(logic [7:0] a, logic [7:0] e);
    rd = 1; addr = a;
    @(posedge clk) #2;
    rd = 0;
    chk("rdata", {8'h00, rdata}, {8'h00, e});
    @(posedge clk) #2;
  endtask
  task automatic results();
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    #2 rst_n = 1;
    rreg(ADDR_INT_EN_2, 8'h00);
    rreg(ADDR_PRIO_HI_2, 8'h00);
    foreach (rows[k]) begin
      wreg(ADDR_INT_EN_1, rows[k].ie1);
      wreg(ADDR_INT_EN_2, rows[k].ie2);
      wreg(ADDR_EXT_PIN_EN, rows[k].pin);
      wreg(ADDR_P1_WAKE, rows[k].p1m);
      flags = rows[k].fl;
      repeat (2) @(posedge clk);
      #2 chk("int_req", req, rows[k].req);
      if (rows[k].req) chk("vector", vec, rows[k].vec);
      chk("stop_wake", swake, rows[k].wake);
      chk("idle_wake", iwake, rows[k].req);
      flags = '0;
    end
    wreg(ADDR_PWM_OUT_EN, 8'hC0);
    wreg(ADDR_PWM_CLR_EN, 8'h80);
    wreg(ADDR_INT_EN_2, 8'h80);
    flags = 31'h0000007;
    @(posedge clk) #2;
    chk("pwm_vector", {15'h0000, req} ^ vec, 16'h0072);
    wreg(ADDR_INT_EN_2, 8'h00);
    chk("pwm_gated", req, 1'b0);
    wreg(ADDR_INT_EN_1, 8'h8A);
    flags = 31'h0000C00;
    @(posedge clk) #2;
    chk("tie_vector", vec, 16'h000B);
    wreg(ADDR_PRIO_HI_1, 8'h08);
    wreg(ADDR_PRIO_LO_1, 8'h08);
    chk("level", lvl, 2'h3);
    chk("top_vector", vec, 16'h001B);
    take = 1;
    repeat (10) if (insvc == 4'h0) @(posedge clk) #2;
    take = 0;
    @(posedge clk) #2;
    chk("in_service", insvc, 4'h8);
    chk("held_req", req, 1'b0);
    reti = 1;
    @(posedge clk) #2;
    reti = 0;
    @(posedge clk) #2;
    chk("returned", insvc, 4'h0);
    chk("again_req", req, 1'b1);
    {slow, take} = 2'h1;
    repeat (2) @(posedge clk) #2;
    take = 0;
    chk("fast_ack", insvc, 4'h8);
    wreg(ADDR_INT_EN_1, 8'hFF);
    cen = 0;
    wreg(ADDR_INT_EN_1, 8'h00);
    cen = 1;
    rreg(ADDR_INT_EN_1, 8'hBF);
    wreg(8'h00, 8'hFF);
    rreg(8'h00, 8'h00);
    results();
  end
endmodule
